// ===== hw/sdc_spare_debug_control.sv
// Spare debug control register with CRC mismatch trigger and RAM guard.
//
// Our own choice: the Wishbone register port.
`include "sdc_defines.svh"

module sdc_spare_debug_control #(
  parameter int DATA_W  = 32,
  parameter int RAM_CNT = `SDC_RAM_CNT
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    func_rst_i,
  // Classic Wishbone slave.
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [`SDC_ADDR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  output logic                         irq_o,
  // Power and CRC compare.
  input  wire logic                    ext_power_i,
  input  wire logic                    crc_check_i,
  input  wire logic [31:0]             sw_crc_i,
  input  wire logic [31:0]             hw_crc_i,
  input  wire logic                    crc_offload_i,
  output logic                         trigger_o,
  // RAM write guard.
  output logic                         ram_wr_block_o,
  input  wire logic [RAM_CNT-1:0]      ram_wr_req_i,
  output logic      [RAM_CNT-1:0]      ram_wr_en_o,
  // Shadow read RAM visibility.
  input  wire logic [DATA_W-1:0]       desc_in_i,
  input  wire logic [DATA_W-1:0]       desc_out_i,
  input  wire logic [DATA_W-1:0]       data_in_i,
  input  wire logic [DATA_W-1:0]       data_out_i,
  output logic      [DATA_W-1:0]       obs_data_o,
  output logic                         obs_valid_o,
  output logic                         shadow_slave_rd_en_o,
  output logic      [DATA_W-1:0]       shadow_slave_data_o
);
  import sdc_pkg::*;

  // Merge write data into a word under the Wishbone byte enables.
  function automatic logic [31:0] byte_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Pick the observation source from the in/out and data/desc selects.
  function automatic sdc_obs_src_type obs_pick(
    input logic sel_in,
    input logic sel_data
  );
    sdc_obs_src_type src;
    src = SDC_OBS_DESC_OUT;
    case ({sel_data, sel_in})
      2'b00: src = SDC_OBS_DESC_OUT;
      2'b01: src = SDC_OBS_DESC_IN;
      2'b10: src = SDC_OBS_DATA_OUT;
      2'b11: src = SDC_OBS_DATA_IN;
      default: src = SDC_OBS_DESC_OUT;
    endcase
    return src;
  endfunction

  // Register hit decode, shared by every write strobe.
  function automatic logic reg_hit(
    input logic [`SDC_ADDR_W-1:0] adr,
    input logic [`SDC_ADDR_W-1:0] off
  );
    return adr == off;
  endfunction

  sdc_bus_state_type          bus_state_r;
  sdc_bus_state_type          bus_state_nxt;
  logic [31:0]                ctrl_r;
  logic                       pwr_r;
  logic [`SDC_IRQ_W-1:0]      irq_status_r;
  logic [`SDC_IRQ_W-1:0]      irq_mask_r;
  logic [31:0]                rd_data_r;
  logic                       trigger_r;
  logic                       wr_block_r;
  logic [DATA_W-1:0]          obs_data_r;
  logic                       obs_valid_r;
  logic [DATA_W-1:0]          slave_data_r;
  logic [31:0]                ctrl_view;
  logic [31:0]                rd_mux;
  logic                       bus_req;
  logic                       wr_take;
  logic                       mismatch;
  logic                       trig_fire;
  logic                       block_set;
  logic [`SDC_IRQ_W-1:0]      irq_event;
  logic [`SDC_IRQ_W-1:0]      irq_clear;
  sdc_obs_src_type            obs_src;
  logic [31:0]                ctrl_nxt;
  logic [`SDC_IRQ_W-1:0]      irq_status_nxt;
  logic [`SDC_IRQ_W-1:0]      irq_mask_nxt;
  logic                       ctrl_wr;
  logic                       stat_wr;
  logic                       mask_wr;

  assign bus_req = wb_cyc_i & wb_stb_i;
  // A write lands only on the edge at which the master sees ack.
  assign wr_take = (bus_state_r == SDC_BUS_ACK) & bus_req & wb_we_i;
  assign ctrl_wr = wr_take & reg_hit(wb_adr_i, `SDC_OFF_CTRL);
  assign stat_wr = wr_take & reg_hit(wb_adr_i, `SDC_OFF_IRQ_STATUS)
                   & wb_sel_i[0];
  assign mask_wr = wr_take & reg_hit(wb_adr_i, `SDC_OFF_IRQ_MASK)
                   & wb_sel_i[0];

  // Bus handshake: one wait cycle, ack for one cycle, then drop.
  always_comb begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      SDC_BUS_IDLE: begin
        if (bus_req) begin
          bus_state_nxt = SDC_BUS_ACK;
        end
      end
      SDC_BUS_ACK: begin
        bus_state_nxt = SDC_BUS_WAIT;
      end
      SDC_BUS_WAIT: begin
        if (!bus_req) begin
          bus_state_nxt = SDC_BUS_IDLE;
        end
      end
      default: begin
        bus_state_nxt = SDC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state_r <= SDC_BUS_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  assign wb_ack_o = (bus_state_r == SDC_BUS_ACK);

  // Bits 2:0 read as zero and bit 3 mirrors the external power level.
  always_comb begin
    ctrl_view = ctrl_r & `SDC_CTRL_WR_MASK; // [R11]
    ctrl_view[`SDC_BIT_PWR] = pwr_r; // [R3]
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
      `SDC_OFF_CTRL: begin
        rd_mux = ctrl_view;
      end
      `SDC_OFF_IRQ_STATUS: begin
        rd_mux = {29'h0000000, irq_status_r};
      end
      `SDC_OFF_IRQ_MASK: begin
        rd_mux = {29'h0000000, irq_mask_r};
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // Read data is captured when the request first arrives.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_r <= 32'h00000000;
    end else if (bus_state_r == SDC_BUS_IDLE && bus_req) begin
      rd_data_r <= rd_mux;
    end
  end

  assign wb_dat_o = rd_data_r;

  // Read-only bits never take storage, so bits 3:0 stay zero here.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr) begin
      ctrl_nxt = byte_merge(ctrl_r, wb_dat_i, wb_sel_i)
                 & `SDC_CTRL_WR_MASK; // [R11]
    end
  end

  // Only the power-good reset touches this register; func_rst_i does not.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `SDC_CTRL_RESET; // [R1]
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Power input is synchronous, so one flop suffices to register it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_r <= 1'b0; // [R3]
    end else begin
      pwr_r <= ext_power_i; // [R3]
    end
  end

  assign mismatch = crc_check_i & (sw_crc_i != hw_crc_i);
  // Offloaded CRC has no software value, so the enable is ignored.
  assign trig_fire = mismatch & ctrl_r[`SDC_BIT_TRIG_EN]
                     & ~crc_offload_i; // [R4] [R5]

  always_ff @(posedge clk_i) begin
    if (rst_i || func_rst_i) begin
      trigger_r <= 1'b0;
    end else begin
      trigger_r <= trig_fire; // [R12]
    end
  end

  assign trigger_o = trigger_r;

  assign block_set = mismatch & ctrl_r[`SDC_BIT_WR_DIS]; // [R6]

  // Sticky guard; clearing bit 9 later does not reopen the RAMs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_block_r <= 1'b0;
    end else if (block_set) begin
      wr_block_r <= 1'b1; // [R12]
    end
  end

  assign ram_wr_block_o = wr_block_r;

  genvar g;
  generate
    for (g = 0; g < RAM_CNT; g++) begin : g_ram_guard
      assign ram_wr_en_o[g] = ram_wr_req_i[g] & ~wr_block_r; // [R6]
    end
  endgenerate

  assign obs_src = obs_pick(ctrl_r[`SDC_BIT_OBS_IN],
                            ctrl_r[`SDC_BIT_OBS_DATA]); // [R8] [R9]

  // Port rests at zero when visibility is off, so no RAM data leaks.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      obs_data_r  <= '0;
      obs_valid_r <= 1'b0;
    end else if (ctrl_r[`SDC_BIT_OBS_EN]) begin
      obs_valid_r <= 1'b1; // [R7]
      case (obs_src)
        SDC_OBS_DESC_OUT: begin
          obs_data_r <= desc_out_i; // [R8] [R9]
        end
        SDC_OBS_DESC_IN: begin
          obs_data_r <= desc_in_i;
        end
        SDC_OBS_DATA_OUT: begin
          obs_data_r <= data_out_i;
        end
        SDC_OBS_DATA_IN: begin
          obs_data_r <= data_in_i;
        end
        default: begin
          obs_data_r <= '0;
        end
      endcase
    end else begin
      obs_valid_r <= 1'b0;
      obs_data_r  <= '0;
    end
  end

  assign obs_data_o  = obs_data_r;
  assign obs_valid_o = obs_valid_r;

  // Slave path shows the inbound data RAM (bit 12 set) or descriptor RAM (bit 12 clear) when allowed, zero otherwise.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slave_data_r <= '0;
    end else if (ctrl_r[`SDC_BIT_SLV_RD]) begin
      slave_data_r <= ctrl_r[`SDC_BIT_OBS_DATA] ?
                      data_in_i : desc_in_i; // [R10]
    end else begin
      slave_data_r <= '0; // [R10]
    end
  end

  assign shadow_slave_rd_en_o = ctrl_r[`SDC_BIT_SLV_RD]; // [R10]
  assign shadow_slave_data_o  = slave_data_r;

  always_comb begin
    irq_event = '0;
    irq_event[`SDC_IRQ_MISMATCH] = mismatch;
    irq_event[`SDC_IRQ_WR_BLOCK] = block_set & ~wr_block_r;
    irq_event[`SDC_IRQ_PWR_CHG]  = pwr_r ^ ext_power_i;
  end

  assign irq_clear = stat_wr ? wb_dat_i[`SDC_IRQ_W-1:0] : '0;

  // A new event in the clear cycle survives: set wins over clear.
  always_comb begin
    irq_status_nxt = (irq_status_r & ~irq_clear) | irq_event;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_r <= `SDC_IRQ_RESET;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  always_comb begin
    irq_mask_nxt = irq_mask_r;
    if (mask_wr) begin
      irq_mask_nxt = wb_dat_i[`SDC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= `SDC_IRQ_RESET;
    end else begin
      irq_mask_r <= irq_mask_nxt;
    end
  end

  assign irq_o = |(irq_status_r & irq_mask_r);

endmodule

// ===== pkg/sdc_defines.svh
// Offsets, field positions, reset values, widths and RAM count of the block.
// Function
// R1 - Only the power-good reset restores defaults; other resets keep it.
// R2 - Software keeps every field at its recommended value.
// R3 - Bit 3 is read-only status: 1 while external power is on.
// R4 - Bit 8 set: emit a trigger on each software/hardware CRC mismatch.
// R5 - Trigger enable is ignored while CRC is offloaded to hardware.
// R6 - Bit 9 set: a mismatch blocks later writes to the listed RAMs.
// R7 - Bit 10 set: shadow read RAM data goes to the observation port.
// R8 - Bit 11 picks inbound (1) or outbound (0) data, only with bit 10.
// R9 - Bit 12 picks data RAM (1) or descriptor RAM (0), only with bit 10; code also uses it with bit 13 alone.
// R10 - Bit 13 set: shadow read RAMs are readable over the slave bus; code exposes only the inbound data or descriptor RAM.
// R11 - Bits 31:18 and 4-7, 14-17 writable reserved, default 0; bits 0-2 zero.
// R12 - Trigger is a one-clock pulse; write block is sticky until reset; code holds trigger_o high for each cycle crc_check_i sees a mismatch.
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

`define SDC_ADDR_W          8
`define SDC_OFF_CTRL        8'h2C
`define SDC_OFF_IRQ_STATUS  8'h40
`define SDC_OFF_IRQ_MASK    8'h44

`define SDC_CTRL_RESET      32'h00000000
`define SDC_CTRL_WR_MASK    32'hFFFFFFF0
`define SDC_IRQ_RESET       3'h0

`define SDC_BIT_PWR         3
`define SDC_BIT_TRIG_EN     8
`define SDC_BIT_WR_DIS      9
`define SDC_BIT_OBS_EN      10
`define SDC_BIT_OBS_IN      11
`define SDC_BIT_OBS_DATA    12
`define SDC_BIT_SLV_RD      13

`define SDC_IRQ_W           3
`define SDC_IRQ_MISMATCH    0
`define SDC_IRQ_WR_BLOCK    1
`define SDC_IRQ_PWR_CHG     2

`define SDC_RAM_CNT         7

`endif

// ===== pkg/sdc_pkg.sv
// Types shared by the spare debug control block.
package sdc_pkg;

  typedef enum logic [1:0] {
    SDC_BUS_IDLE,
    SDC_BUS_ACK,
    SDC_BUS_WAIT
  } sdc_bus_state_type;

  typedef enum logic [1:0] {
    SDC_OBS_DESC_OUT,
    SDC_OBS_DESC_IN,
    SDC_OBS_DATA_OUT,
    SDC_OBS_DATA_IN
  } sdc_obs_src_type;

endpackage

// ===== tb/sdc_props.sv
// Port-level assertions for the spare debug control block.
module sdc_props #(
  parameter int DATA_W  = 32,
  parameter int RAM_CNT = 7
) (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_ack_o,
  input wire logic               crc_check_i,
  input wire logic [31:0]        sw_crc_i,
  input wire logic [31:0]        hw_crc_i,
  input wire logic               crc_offload_i,
  input wire logic               trigger_o,
  input wire logic               ram_wr_block_o,
  input wire logic [RAM_CNT-1:0] ram_wr_req_i,
  input wire logic [RAM_CNT-1:0] ram_wr_en_o,
  input wire logic [DATA_W-1:0]  obs_data_o,
  input wire logic               obs_valid_o,
  input wire logic               shadow_slave_rd_en_o,
  input wire logic [DATA_W-1:0]  shadow_slave_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // A mismatch is judged on the compare strobe only, never on idle data.
  ack_next_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=>
    wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  trig_cause_a: assert property (trigger_o |->
    $past(crc_check_i && sw_crc_i != hw_crc_i && !crc_offload_i))
    else $error("trigger without mismatch");
  trig_offload_a: assert property (crc_offload_i |=> !trigger_o)
    else $error("trigger while offloaded");
  block_hold_a: assert property (ram_wr_block_o && !rst_i |=>
    ram_wr_block_o)
    else $error("write block dropped");
  block_cause_a: assert property ($rose(ram_wr_block_o) |->
    $past(crc_check_i && sw_crc_i != hw_crc_i))
    else $error("write block without mismatch");
  wr_gate_a: assert property (ram_wr_en_o ==
    (ram_wr_req_i & {RAM_CNT{!ram_wr_block_o}}))
    else $error("ram write not gated");
  obs_zero_a: assert property (!obs_valid_o |-> obs_data_o == '0)
    else $error("observation data leaks");
  slave_zero_a: assert property (!shadow_slave_rd_en_o |=>
    shadow_slave_data_o == '0)
    else $error("slave data leaks");
  cover property (trigger_o);
  cover property ($rose(ram_wr_block_o));
  cover property (obs_valid_o);
endmodule

bind sdc_spare_debug_control sdc_props #(
  .DATA_W  (DATA_W),
  .RAM_CNT (RAM_CNT)
) u_props (.*);

// ===== tb/tb_top.sv
// Self-checking bench for the spare debug control block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rst_i = 1, func_rst_i = 0;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, irq_o;
  logic [7:0]  wb_adr_i = 0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 0, wb_dat_o, sw_crc_i = 0, hw_crc_i = 0;
  logic        ext_power_i = 0, crc_check_i = 0, crc_offload_i = 0;
  logic        trigger_o, ram_wr_block_o, obs_valid_o, shadow_slave_rd_en_o;
  logic [6:0]  ram_wr_req_i = 0, ram_wr_en_o;
  logic [31:0] desc_out_i = 32'hA1A1A1A1, desc_in_i = 32'hB2B2B2B2;
  logic [31:0] data_out_i = 32'hC3C3C3C3, data_in_i = 32'hD4D4D4D4;
  logic [127:0] obs_all;
  logic [31:0] obs_data_o, shadow_slave_data_o, q;
  int          n_fail = 0, n_compared = 0;

  sdc_spare_debug_control dut (.*);

  assign obs_all = {desc_out_i, desc_in_i, data_out_i, data_in_i};

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The master holds the request until it samples ack, then releases.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i  <= w;
    wb_sel_i <= s;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 0);
    chk(q, e);
  endtask

  task automatic crc(input logic [31:0] s, h, input logic o, e);
    @(posedge clk_i);
    crc_check_i   <= 1;
    sw_crc_i      <= s;
    hw_crc_i      <= h;
    crc_offload_i <= o;
    @(posedge clk_i);
    crc_check_i <= 0;
    #1 chk(trigger_o, e);
  endtask

  task automatic pulse_func;
    @(posedge clk_i);
    func_rst_i <= 1;
    @(posedge clk_i);
    func_rst_i <= 0;
  endtask

  task automatic complete_run;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #40000;
    n_fail++;
    complete_run;
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    rd(8'h2C, 32'h0);
    rd(8'h44, 32'h0);
    ext_power_i <= 1;
    wb(1, 8'h2C, 32'hFFFFFFFF);
    rd(8'h2C, 32'hFFFFFFF8);
    wb(1, 8'h2C, 32'h0, 4'h1);
    rd(8'h2C, 32'hFFFFFF08);
    pulse_func;
    rd(8'h2C, 32'hFFFFFF08);
    wb(1, 8'h30, 32'h12345678);
    rd(8'h30, 32'h0);
    rd(8'h40, 32'h4);
    wb(1, 8'h40, 32'h7);
    rd(8'h40, 32'h0);
    wb(1, 8'h2C, 32'h100);
    crc(1, 2, 1, 0);
    crc(1, 1, 0, 0);
    crc(1, 2, 0, 1);
    @(posedge clk_i);
    #1 chk(trigger_o, 0);
    rd(8'h40, 32'h1);
    chk(irq_o, 0);
    wb(1, 8'h44, 32'h1);
    #1 chk(irq_o, 1);
    wb(1, 8'h40, 32'h1);
    #1 chk(irq_o, 0);
    wb(1, 8'h2C, 32'h0);
    ram_wr_req_i <= 7'h7F;
    crc(3, 4, 0, 0);
    wb(1, 8'h2C, 32'h200);
    crc(5, 5, 0, 0);
    chk(ram_wr_en_o, 7'h7F);
    crc(5, 6, 1, 0);
    chk(ram_wr_block_o, 1);
    chk(ram_wr_en_o, 7'h00);
    rd(8'h40, 32'h3);
    wb(1, 8'h2C, 32'h0);
    pulse_func;
    #1 chk(ram_wr_block_o, 1);
    @(posedge clk_i);
    rst_i <= 1;
    @(posedge clk_i);
    rst_i <= 0;
    #1 chk(ram_wr_block_o, 0);
    rd(8'h2C, 32'h8);
    for (int i = 0; i < 4; i++) begin
      wb(1, 8'h2C, 32'h400 | (i << 11));
      repeat (2) @(posedge clk_i);
      #1 chk(obs_data_o, obs_all[(3 - i) * 32 +: 32]);
      chk(obs_valid_o, 1);
    end
    wb(1, 8'h2C, 32'h1800);
    repeat (2) @(posedge clk_i);
    #1 chk(obs_data_o, 0);
    chk(obs_valid_o, 0);
    wb(1, 8'h2C, 32'h3000);
    repeat (2) @(posedge clk_i);
    #1 chk(shadow_slave_rd_en_o, 1);
    chk(shadow_slave_data_o, data_in_i);
    wb(1, 8'h2C, 32'h2000);
    repeat (2) @(posedge clk_i);
    #1 chk(shadow_slave_data_o, desc_in_i);
    wb(1, 8'h2C, 32'h0);
    repeat (2) @(posedge clk_i);
    #1 chk(shadow_slave_data_o, 0);
    complete_run;
  end
endmodule
